// ### hdl/gencfg_pkg.sv
// constants for the deserializer general configuration block
// assumes one pixel clock domain and a byte-wide internal register port
package gencfg_pkg;

   // register offsets on the internal register port
   localparam logic [7:0] RESET_CTRL_ADDR = 8'h01;
   localparam logic [7:0] OUTPUT_AND_CLOCK_CONFIG_ADDR = 8'h02;
   localparam logic [7:0] LINK_AND_INPUT_CONFIG_ADDR = 8'h03;

   // values after reset
   localparam logic [7:0] RESET_CTRL_RESET = 8'h04;
   localparam logic [7:0] OUTPUT_AND_CLOCK_CONFIG_RESET = 8'h80;
   localparam logic [7:0] LINK_AND_INPUT_CONFIG_RESET = 8'hf0;

   // reset control fields
   localparam int LOGIC_RESET_KEEP_REGS_BIT = 0;
   localparam int FULL_LOGIC_RESET_BIT = 1;
   localparam logic [7:0] RESET_CTRL_SC_MASK = 8'h03;

   // output_and_clock_config fields
   localparam int OUT_DRIVE_EN_BIT = 7;
   localparam int OUT_OVERRIDE_BIT = 6;
   localparam int LOCKLOSS_CLOCK_SUBSTITUTE_BIT = 5;
   localparam int IDLE_STATE_SHORT_BIT = 4;

   // link_and_input_config fields
   localparam int RETURN_LINK_CHECK_GEN_BIT = 6;
   localparam int UNDRIVEN_PULL_POLARITY_BIT = 5;
   localparam int SYNC_FILTER_EN_BIT = 4;
   localparam int I2C_FORWARD_EN_BIT = 3;
   localparam int I2C_AUTO_ACK_BIT = 2;
   localparam int PIXEL_GATING_BY_ACTIVE_FLAG_BIT = 1;

   // defaults applied while the override is off
   localparam logic OUT_DRIVE_EN_DEFAULT = 1'b1;
   localparam logic IDLE_STATE_SHORT_DEFAULT = 1'b1;

   // glitch filter lengths in pixel clock cycles
   localparam logic [1:0] FILTER_CYCLES_ONE_LANE = 2'h2;
   localparam logic [2:0] FILTER_CYCLES_TWO_LANE = 3'h4;

   // substitute clock: half period is 2**(sel+1) cycles
   localparam int OSC_DIV_W = 5;

endpackage : gencfg_pkg

// ### hdl/sync_filter_if.sv
// carries the sync/active flags between the config block and its glitch filter
// assumes both ends run on the same pixel clock
`timescale 1ns/1ps
`default_nettype none
interface sync_filter_if;
   logic enable;
   logic dual_lane;
   logic clear;
   logic [2:0] raw;
   logic [2:0] clean;

   modport ctrl (output enable, output dual_lane, output clear, output raw, input clean);
   modport filt (input enable, input dual_lane, input clear, input raw, output clean);
endinterface : sync_filter_if
`default_nettype wire

// ### hdl/sync_glitch_filter.sv
// glitch filter for the active, horizontal and vertical sync flags
// assumes flags arrive already on the pixel clock
`timescale 1ns/1ps
`default_nettype none
module sync_glitch_filter
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   sync_filter_if.filt f
);

   logic [2:0] len;

   // needed stability length follows lane mode
   assign len = f.dual_lane ? gencfg_pkg::FILTER_CYCLES_TWO_LANE
                            : {1'b0, gencfg_pkg::FILTER_CYCLES_ONE_LANE};

   ///////////////////////////////////////////////////////////////////////
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_flag
         logic [2:0] cnt_q;
         logic out_q;

         // with the filter enabled a new level is taken only once it has stood len cycles; disabled, it is taken on the next edge
         always_ff @(posedge ref_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               cnt_q <= 3'h0;
               out_q <= 1'b0;
            end
            else if (f.clear)
            begin
               cnt_q <= 3'h0;
               out_q <= 1'b0;
            end
            else if (!f.enable)
            begin
               cnt_q <= 3'h0;
               out_q <= f.raw[g];
            end
            else if (f.raw[g] == out_q)
               cnt_q <= 3'h0; // short pulse discarded
            // at-or-above so a lane change mid-count cannot strand the counter
            else if (cnt_q >= len - 3'h1)
            begin
               cnt_q <= 3'h0;
               out_q <= f.raw[g];
            end
            else
               cnt_q <= cnt_q + 3'h1;
         end
         assign f.clean[g] = out_q;
      end
   endgenerate

endmodule : sync_glitch_filter
`default_nettype wire

// ### hdl/deserializer_general_config.sv
// general configuration registers and the output control they steer
// assumes a byte register port fed by the I2C slave / remote control path,
// all link-side inputs on ref_clk_i except the lock pin
`timescale 1ns/1ps
`default_nettype none

module deserializer_general_config
#(
   parameter int PIXEL_W = 24
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // internal register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // link state
   input wire logic lock_pin_i,
   input wire logic dual_lane_i,
   input wire logic protected_ser_i,
   input wire logic [1:0] osc_freq_sel_i,
   // recovered video
   input wire logic [PIXEL_W-1:0] pixel_i,
   input wire logic active_i,
   input wire logic hsync_i,
   input wire logic vsync_i,
   // video outputs
   output logic [PIXEL_W-1:0] pixel_o,
   output logic active_o,
   output logic hsync_o,
   output logic vsync_o,
   output logic out_oe_n_o,
   output logic pclk_o,
   // static controls
   output logic return_link_check_gen_o,
   output logic undriven_pull_polarity_o,
   // I2C path
   input wire logic i2c_addr_match_i,
   input wire logic i2c_write_i,
   output logic i2c_forward_o,
   output logic i2c_auto_ack_o
);

   ///////////////////////////////////////////////////////////////////////
   logic [7:0] reset_ctrl_q;
   logic [7:0] out_cfg_q;
   logic [7:0] link_cfg_q;
   logic lock_meta_q;
   logic lock_q;
   logic full_rst_q;
   logic logic_rst_q;
   logic eff_drive_en;
   logic eff_idle_state;
   logic gate_en;
   logic [gencfg_pkg::OSC_DIV_W-1:0] osc_cnt_q;
   logic [gencfg_pkg::OSC_DIV_W-1:0] osc_half;
   logic [7:0] rdata_d;

   sync_filter_if flt ();

   ///////////////////////////////////////////////////////////////////////
   // lock comes from the clock recovery pin through a two-flop synchronizer
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_meta_q <= 1'b0;
         lock_q <= 1'b0;
      end
      else
      begin
         lock_meta_q <= lock_pin_i;
         lock_q <= lock_meta_q;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // self-clearing reset requests; held one cycle so the write is visible
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reset_ctrl_q <= gencfg_pkg::RESET_CTRL_RESET;
      else if (full_rst_q)
         reset_ctrl_q <= gencfg_pkg::RESET_CTRL_RESET;
      else if (reg_wr_i && reg_addr_i == gencfg_pkg::RESET_CTRL_ADDR)
         reset_ctrl_q <= reg_wdata_i;
      else
         reset_ctrl_q <= reset_ctrl_q & ~gencfg_pkg::RESET_CTRL_SC_MASK;
   end

   // pulses that reset the datapath one cycle after the request lands
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         full_rst_q <= 1'b0;
         logic_rst_q <= 1'b0;
      end
      else
      begin
         full_rst_q <= reset_ctrl_q[gencfg_pkg::FULL_LOGIC_RESET_BIT];
         logic_rst_q <= reset_ctrl_q[gencfg_pkg::FULL_LOGIC_RESET_BIT]
                        | reset_ctrl_q[gencfg_pkg::LOGIC_RESET_KEEP_REGS_BIT];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // configuration storage; reserved bits kept as written
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         out_cfg_q <= gencfg_pkg::OUTPUT_AND_CLOCK_CONFIG_RESET;
      else if (full_rst_q)
         out_cfg_q <= gencfg_pkg::OUTPUT_AND_CLOCK_CONFIG_RESET;
      else if (reg_wr_i && reg_addr_i == gencfg_pkg::OUTPUT_AND_CLOCK_CONFIG_ADDR)
         out_cfg_q <= reg_wdata_i;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         link_cfg_q <= gencfg_pkg::LINK_AND_INPUT_CONFIG_RESET;
      else if (full_rst_q)
         link_cfg_q <= gencfg_pkg::LINK_AND_INPUT_CONFIG_RESET;
      else if (reg_wr_i && reg_addr_i == gencfg_pkg::LINK_AND_INPUT_CONFIG_ADDR)
         link_cfg_q <= reg_wdata_i;
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_d = 8'h00;
      unique case (reg_addr_i)
         gencfg_pkg::RESET_CTRL_ADDR: rdata_d = reset_ctrl_q;
         gencfg_pkg::OUTPUT_AND_CLOCK_CONFIG_ADDR: rdata_d = out_cfg_q;
         gencfg_pkg::LINK_AND_INPUT_CONFIG_ADDR: rdata_d = link_cfg_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= rdata_d;
   end

   ///////////////////////////////////////////////////////////////////////
   // effective drive enable and idle state; defaults unless overridden
   assign eff_drive_en = out_cfg_q[gencfg_pkg::OUT_OVERRIDE_BIT]
                         ? out_cfg_q[gencfg_pkg::OUT_DRIVE_EN_BIT]
                         : gencfg_pkg::OUT_DRIVE_EN_DEFAULT;
   assign eff_idle_state = out_cfg_q[gencfg_pkg::OUT_OVERRIDE_BIT]
                           ? out_cfg_q[gencfg_pkg::IDLE_STATE_SHORT_BIT]
                           : gencfg_pkg::IDLE_STATE_SHORT_DEFAULT;

   // a protected serializer forces gating, audio packets need it otherwise
   assign gate_en = protected_ser_i
                    | link_cfg_q[gencfg_pkg::PIXEL_GATING_BY_ACTIVE_FLAG_BIT];

   ///////////////////////////////////////////////////////////////////////
   // sync/active glitch filtering
   assign flt.enable = link_cfg_q[gencfg_pkg::SYNC_FILTER_EN_BIT];
   assign flt.dual_lane = dual_lane_i;
   assign flt.clear = logic_rst_q;
   assign flt.raw = {vsync_i, hsync_i, active_i};

   sync_glitch_filter u_filter
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .f(flt)
   );

   ///////////////////////////////////////////////////////////////////////
   // video outputs: locked passes data, unlocked shows the idle state;
   // idle state 1 holds outputs low, 0 releases them, drive off floats them
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pixel_o <= '0;
         active_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
         out_oe_n_o <= 1'b1;
      end
      else if (logic_rst_q)
      begin
         pixel_o <= '0;
         active_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
         out_oe_n_o <= 1'b1;
      end
      else if (lock_q)
      begin
         pixel_o <= (gate_en && !flt.clean[0]) ? '0 : pixel_i;
         active_o <= flt.clean[0];
         hsync_o <= flt.clean[1];
         vsync_o <= flt.clean[2];
         out_oe_n_o <= ~eff_drive_en;
      end
      else
      begin
         pixel_o <= '0;
         active_o <= 1'b0;
         hsync_o <= 1'b0;
         vsync_o <= 1'b0;
         out_oe_n_o <= ~(eff_drive_en & eff_idle_state);
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // pixel clock: follows data when locked, substitute oscillator when not;
   // the substitute is a divided ref_clk since no free oscillator is modelled
   // shift amount widened first: a 2-bit sum would wrap to zero for select 3
   assign osc_half = gencfg_pkg::OSC_DIV_W'(1) << ({1'b0, osc_freq_sel_i} + 3'h1);

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         osc_cnt_q <= '0;
         pclk_o <= 1'b0;
      end
      else if (logic_rst_q)
      begin
         osc_cnt_q <= '0;
         pclk_o <= 1'b0;
      end
      else if (lock_q)
      begin
         osc_cnt_q <= '0;
         pclk_o <= ~pclk_o;
      end
      else if (out_cfg_q[gencfg_pkg::LOCKLOSS_CLOCK_SUBSTITUTE_BIT])
      begin
         if (osc_cnt_q >= osc_half - gencfg_pkg::OSC_DIV_W'(1))
         begin
            osc_cnt_q <= '0;
            pclk_o <= ~pclk_o;
         end
         else
            osc_cnt_q <= osc_cnt_q + gencfg_pkg::OSC_DIV_W'(1);
      end
      else
      begin
         osc_cnt_q <= '0;
         pclk_o <= 1'b0;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // static controls registered so the pins see clean levels
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         return_link_check_gen_o <= gencfg_pkg::LINK_AND_INPUT_CONFIG_RESET[
            gencfg_pkg::RETURN_LINK_CHECK_GEN_BIT];
         undriven_pull_polarity_o <= gencfg_pkg::LINK_AND_INPUT_CONFIG_RESET[
            gencfg_pkg::UNDRIVEN_PULL_POLARITY_BIT];
      end
      else
      begin
         return_link_check_gen_o <= link_cfg_q[gencfg_pkg::RETURN_LINK_CHECK_GEN_BIT];
         undriven_pull_polarity_o <= link_cfg_q[gencfg_pkg::UNDRIVEN_PULL_POLARITY_BIT];
      end
   end

   // I2C forward and local acknowledge decisions
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         i2c_forward_o <= 1'b0;
         i2c_auto_ack_o <= 1'b0;
      end
      else if (logic_rst_q)
      begin
         i2c_forward_o <= 1'b0;
         i2c_auto_ack_o <= 1'b0;
      end
      else
      begin
         i2c_forward_o <= i2c_addr_match_i & link_cfg_q[gencfg_pkg::I2C_FORWARD_EN_BIT];
         i2c_auto_ack_o <= i2c_write_i & link_cfg_q[gencfg_pkg::I2C_AUTO_ACK_BIT];
      end
   end

endmodule : deserializer_general_config
`default_nettype wire

// ### verif/gencfg_chk.sv
// concurrent checks on the ports of the general configuration block
// assumes one pixel clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module gencfg_chk
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic lock_pin_i,
   input wire logic i2c_addr_match_i,
   input wire logic i2c_write_i,
   input wire logic i2c_forward_o,
   input wire logic i2c_auto_ack_o,
   input wire logic return_link_check_gen_o,
   input wire logic undriven_pull_polarity_o,
   input wire logic out_oe_n_o,
   input wire logic pclk_o,
   input wire logic active_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   // a lone write to the third register (offset 03); quiet edges keep soft resets out of the way
   sequence s_w3;
      !reg_wr_i [*2] ##1 reg_wr_i && reg_addr_i == 8'h03 ##1 !reg_wr_i;
   endsequence
   property p_pull;
      s_w3 |=> undriven_pull_polarity_o == $past(reg_wdata_i[5], 2);
   endproperty
   a_pull: assert property (p_pull) else $error("pull select not copied");
   property p_crc;
      s_w3 |=> return_link_check_gen_o == $past(reg_wdata_i[6], 2);
   endproperty
   a_crc: assert property (p_crc) else $error("check gen not copied");
   property p_fwd;
      s_w3 |=> i2c_forward_o == ($past(i2c_addr_match_i) && $past(reg_wdata_i[3], 2));
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward wrong");
   property p_ack;
      s_w3 |=> i2c_auto_ack_o == ($past(i2c_write_i) && $past(reg_wdata_i[2], 2));
   endproperty
   a_ack: assert property (p_ack) else $error("auto ack wrong");
   property p_rd;
      reg_rd_i && (reg_addr_i == 8'h00 || reg_addr_i > 8'h03) |=> reg_rdata_o == 8'h00;
   endproperty
   a_rd: assert property (p_rd) else $error("unmapped read not zero");
   property p_rst;
      $rose(rst_n_i) |-> return_link_check_gen_o && undriven_pull_polarity_o && out_oe_n_o;
   endproperty
   a_rst: assert property (p_rst) else $error("reset outputs wrong");
   property p_unlock;
      !lock_pin_i [*5] |-> !active_o;
   endproperty
   a_unlock: assert property (p_unlock) else $error("video while unlocked");
   // override off, or override with drive low: the pin state no longer depends on lock
   property p_oe;
      !reg_wr_i [*2] ##1 reg_wr_i && reg_addr_i == 8'h02 && !(reg_wdata_i[6] && reg_wdata_i[7])
         ##1 !reg_wr_i [*2] |=> out_oe_n_o == $past(reg_wdata_i[6], 3);
   endproperty
   a_oe: assert property (p_oe) else $error("output enable wrong");
   property p_soft;
      reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[1:0] != 2'h0
         |-> ##3 !pclk_o && !i2c_forward_o && !i2c_auto_ack_o;
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset missed");
   c_fwd: cover property (i2c_forward_o);
   c_float: cover property (out_oe_n_o ##1 !out_oe_n_o);
   c_pclk: cover property ($rose(pclk_o));
endmodule : gencfg_chk
bind deserializer_general_config gencfg_chk gencfg_chk_i (.ref_clk_i, .rst_n_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .lock_pin_i, .i2c_addr_match_i,
   .i2c_write_i, .i2c_forward_o, .i2c_auto_ack_o, .return_link_check_gen_o,
   .undriven_pull_polarity_o, .out_oe_n_o, .pclk_o, .active_o);
`default_nettype wire

// ### verif/video_src.sv
// remote end model: recovered pixel words and a periodic active flag
// assumes the bench hands it a fresh random word every cycle
`timescale 1ns/1ps
`default_nettype none
module video_src
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [23:0] rnd_i,
   output logic [23:0] pixel_o,
   output logic active_o
);
   logic [3:0] cnt_q;
   // eight active, eight blank; blank words stay random so gating is visible
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= 4'h0;
         pixel_o <= 24'h0;
      end
      else
      begin
         cnt_q <= cnt_q + 4'h1;
         pixel_o <= rnd_i;
      end
   end
   assign active_o = cnt_q[3];
endmodule : video_src
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the general configuration block
// assumes the design, its package and the remote end model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module testbench;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic lock = 1'b0;
   logic dual = 1'b0;
   logic prot = 1'b0;
   logic [1:0] sel = 2'h0;
   logic hs = 1'b0;
   logic match = 1'b0;
   logic wrt = 1'b0;
   logic [31:0] lfsr_q = 32'hfd5a5a90;
   logic [23:0] pix, pp, pix_o;
   logic act, act_o, hs_o, vs_o, oe_n, pclk, crc, pull, fwd, ack, e;
   logic mh, wh;
   logic [4:0] ah;
   logic [7:0] rdata, d;
   logic [1:0] seen;
   int n;
   int err_count = 0;
   int total_checks = 0;
   always #12.5 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////
   function automatic logic [31:0] next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next
   // history of what the design sampled, then fresh random levels just after the edge
   always @(posedge ref_clk_i)
   begin
      pp <= pix;
      ah <= {ah[3:0], act};
      mh <= match;
      wh <= wrt;
      #2;
      lfsr_q = next(lfsr_q);
      match = lfsr_q[3];
      wrt = lfsr_q[9];
   end
   task automatic cyc(input int c);
      repeat (c) @(posedge ref_clk_i);
      #2;
   endtask : cyc
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      cyc(1);
      wr = 1'b1;
      addr = a;
      wdata = v;
      cyc(1);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] v);
      cyc(1);
      rd = 1'b1;
      addr = a;
      cyc(1);
      rd = 1'b0;
      `CHK("rdata", v, rdata)
   endtask : rd_reg
   task automatic summarize();
      if (err_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // bounded wait for the next pclk change; gives the edges counted
   task automatic half(output int c);
      logic p;
      p = pclk;
      c = 0;
      do
      begin
         cyc(1);
         c++;
      end
      while (pclk === p && c < 100);
      if (c == 100)
      begin
         err_count++;
         summarize();
      end
   endtask : half
   video_src video_src_i (.ref_clk_i, .rst_n_i, .rnd_i(lfsr_q[23:0]), .pixel_o(pix),
      .active_o(act));
   deserializer_general_config deserializer_general_config_i (.ref_clk_i, .rst_n_i,
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .lock_pin_i(lock), .dual_lane_i(dual), .protected_ser_i(prot),
      .osc_freq_sel_i(sel), .pixel_i(pix), .active_i(act), .hsync_i(hs), .vsync_i(hs),
      .pixel_o(pix_o), .active_o(act_o), .hsync_o(hs_o), .vsync_o(vs_o), .out_oe_n_o(oe_n),
      .pclk_o(pclk), .return_link_check_gen_o(crc), .undriven_pull_polarity_o(pull),
      .i2c_addr_match_i(match), .i2c_write_i(wrt), .i2c_forward_o(fwd), .i2c_auto_ack_o(ack));
   ////////////////////////////////////////
   // reset values, storage, soft resets, output enable, gating, filter, substitute clock
   initial
   begin
      cyc(20);
      rst_n_i = 1'b1;
      `CHK("oe_n_rst", 1'b1, oe_n)
      cyc(1);
      `CHK("oe_n", 1'b0, oe_n)
      rd_reg(8'h01, 8'h04);
      rd_reg(8'h02, 8'h80);
      rd_reg(8'h03, 8'hf0);
      wr_reg(8'h00, 8'hff);
      rd_reg(8'h00, 8'h00);
      rd_reg(8'h24, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         d = i == 0 ? 8'hff : lfsr_q[7:0];
         wr_reg(8'h02, d);
         rd_reg(8'h02, d);
         wr_reg(8'h03, ~d);
         rd_reg(8'h03, ~d);
         `CHK("pull", ~d[5], pull)
         `CHK("crc", ~d[6], crc)
         `CHK("fwd", mh & ~d[3], fwd)
         `CHK("ack", wh & ~d[2], ack)
      end
      wr_reg(8'h03, 8'h00);
      wr_reg(8'h01, 8'h05);
      cyc(4);
      rd_reg(8'h03, 8'h00);
      rd_reg(8'h01, 8'h04);
      wr_reg(8'h01, 8'h06);
      cyc(4);
      rd_reg(8'h03, 8'hf0);
      rd_reg(8'h01, 8'h04);
      for (int i = 0; i < 5; i++)
      begin
         d = i == 0 ? 8'h40 : i == 1 ? 8'hc0 : i == 2 ? 8'hd0 : i == 3 ? 8'h10 : 8'h80;
         wr_reg(8'h02, d);
         if (i == 1)
            wr_reg(8'h01, 8'h05);
         cyc(4);
         `CHK("oe_n", i < 2, oe_n)
      end
      lock = 1'b1;
      cyc(4);
      half(n);
      `CHK("half_lock", 1, n)
      for (int g = 0; g < 4; g++)
      begin
         prot = g[1];
         wr_reg(8'h03, {6'h3c, g[0], 1'b0});
         repeat (40)
         begin
            cyc(1);
            if (ah == 5'h1f || ah == 5'h00)
            begin
               `CHK("pixel", (g != 0 && ah == 5'h00) ? 24'h0 : pp, pix_o)
               `CHK("active", ah[0], act_o)
            end
         end
      end
      for (int k = 0; k < 8; k++)
      begin
         dual = k[2];
         e = k[1:0] + 1 >= (dual ? 4 : 2);
         hs = 1'b1;
         seen = 2'h0;
         for (int c = 0; c < 12; c++)
         begin
            cyc(1);
            if (c == k[1:0])
               hs = 1'b0;
            seen |= {hs_o, vs_o};
         end
         `CHK("sync", {e, e}, seen)
      end
      lock = 1'b0;
      wr_reg(8'h02, 8'h20);
      for (int s = 0; s < 4; s++)
      begin
         sel = s[1:0];
         repeat (3) half(n);
         `CHK("half", 2 ** (s + 1), n)
      end
      wr_reg(8'h02, 8'h00);
      cyc(4);
      seen = 2'h0;
      repeat (20)
      begin
         cyc(1);
         seen[0] |= pclk;
      end
      `CHK("pclk", 2'h0, seen)
      summarize();
   end
endmodule : testbench
`default_nettype wire
